/* File: core/sfpb_core.sv */
// Purpose: Serial command front end for the page buffer: clear, load, read, write.
// Assumes: Mode 0 serial timing; pins synchronous to i_sys_clk, serial clock slower.
// Notes:   Main memory is reached through a combinational read port.
`timescale 1ns/1ps
module sfpb_core
    import sfpb_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Serial pins
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic [3:0]  i_io,
    output logic      [3:0]  o_io,
    output logic      [3:0]  o_io_oe,
    // Mode and status
    input  wire logic        i_quad_command_mode,
    input  wire logic        i_ext_busy,
    output logic             o_write_in_progress_flag,
    // Main memory read port
    output logic             o_mem_rd,
    output logic      [23:0] o_mem_addr,
    input  wire logic [7:0]  i_mem_rdata
);

    sfpb_state_e state, next_state;
    sfpb_busy_e  busy, next_busy;
    logic        cs_q, next_cs_q;
    logic        sclk_q, next_sclk_q;
    logic [7:0]  cmd, next_cmd;
    logic [7:0]  sh, next_sh;
    logic [3:0]  bcnt, next_bcnt;
    logic [1:0]  abyte, next_abyte;
    logic [23:0] addr, next_addr;
    logic [7:0]  ptr, next_ptr;
    logic [7:0]  out_sh, next_out_sh;
    logic [15:0] busy_cnt, next_busy_cnt;
    logic [15:0] page, next_page;

    logic        sclk_rise, sclk_fall, byte_done, fill_on;
    logic [3:0]  step, bcnt_sum;
    logic [7:0]  shifted;
    logic        ram_we;
    logic [7:0]  ram_waddr, ram_wdata, ram_q;

    sfpb_buf_ram u_ram (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_we      (ram_we),
        .i_waddr   (ram_waddr),
        .i_wdata   (ram_wdata),
        .i_raddr   (ptr),
        .o_rdata   (ram_q)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state    = state;
        next_busy     = busy;
        next_cs_q     = i_cs_n;
        next_sclk_q   = i_sclk;
        next_cmd      = cmd;
        next_sh       = sh;
        next_bcnt     = bcnt;
        next_abyte    = abyte;
        next_addr     = addr;
        next_ptr      = ptr;
        next_out_sh   = out_sh;
        next_busy_cnt = busy_cnt;
        next_page     = page;
        ram_we        = 1'b0;
        ram_waddr     = ptr;
        ram_wdata     = sh;

        sclk_rise = !sclk_q && i_sclk && !i_cs_n;
        sclk_fall = sclk_q && !i_sclk && !i_cs_n;
        step      = i_quad_command_mode ? STEP_QUAD : STEP_SINGLE;
        bcnt_sum  = bcnt + step;
        byte_done = (bcnt_sum == BYTE_BITS);
        shifted   = i_quad_command_mode ? {sh[3:0], i_io} : {sh[6:0], i_io[0]};
        fill_on   = (busy_cnt < {7'h00, BUF_DEPTH});

        // Self-timed fill; busy flag stays up for the full latency
        if (busy != BUSY_NONE) begin
            if (fill_on) begin
                ram_we    = 1'b1;
                ram_waddr = busy_cnt[7:0];
                ram_wdata = (busy == BUSY_CLEAR) ? FILL_BYTE : i_mem_rdata;
            end
            next_busy_cnt = busy_cnt + 16'h0001;
            if ((busy == BUSY_CLEAR && busy_cnt == CLEAR_CYCLES - 16'h0001) ||
                (busy == BUSY_LOAD && busy_cnt == XFER_CYCLES - 16'h0001)) begin
                next_busy = BUSY_NONE;
            end
        end

        if (i_cs_n) begin
            next_state = ST_IDLE;
            if (!cs_q && state == ST_ARMED && busy == BUSY_NONE) begin
                next_busy_cnt = 16'h0000;
                next_page     = addr[23:8];
                next_busy     = (cmd == OP_BUF_CLEAR) ? BUSY_CLEAR : BUSY_LOAD;
            end
        end else if (cs_q) begin
            // Commands during a self-timed cycle would corrupt the fill
            next_state = (busy != BUSY_NONE) ? ST_IGNORE : ST_OP;
            next_bcnt  = 4'h0;
        end else if (sclk_rise && state != ST_IDLE && state != ST_RDATA
                     && state != ST_IGNORE) begin
            next_sh   = shifted;
            next_bcnt = byte_done ? 4'h0 : bcnt_sum;
            if (state == ST_ARMED) begin
                next_state = ST_IGNORE;
            end else if (byte_done) begin
                case (state)
                    ST_OP: begin
                        next_cmd   = shifted;
                        next_abyte = 2'h0;
                        if (shifted == OP_BUF_CLEAR) begin
                            next_state = ST_ARMED;
                        end else if (shifted == OP_BUF_LOAD || shifted == OP_BUF_WRITE) begin
                            next_state = ST_ADDR;
                        end else if (shifted == OP_BUF_READ) begin
                            next_state = i_ext_busy ? ST_IGNORE : ST_ADDR;
                        end else begin
                            next_state = ST_IGNORE;
                        end
                    end
                    ST_ADDR: begin
                        next_addr  = {addr[15:0], shifted};
                        next_abyte = abyte + 2'h1;
                        next_ptr   = shifted;
                        if (abyte == ADDR_LAST) begin
                            if (cmd == OP_BUF_LOAD) begin
                                next_state = ST_ARMED;
                            end else if (cmd == OP_BUF_READ) begin
                                next_state = ST_DUMMY;
                            end else begin
                                next_state = ST_WDATA;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        next_state = ST_RDATA;
                    end
                    ST_WDATA: begin
                        if (busy == BUSY_NONE) begin
                            ram_we    = 1'b1;
                            ram_waddr = ptr;
                            ram_wdata = shifted;
                        end
                        next_ptr = ptr + 8'h01;
                    end
                    default: begin
                        next_state = ST_IGNORE;
                    end
                endcase
            end
        end else if (sclk_fall && state == ST_RDATA) begin
            next_bcnt = byte_done ? 4'h0 : bcnt_sum;
            if (bcnt == 4'h0) begin
                next_out_sh = ram_q;
                next_ptr    = ptr + 8'h01;
            end else if (i_quad_command_mode) begin
                next_out_sh = {out_sh[3:0], 4'h0};
            end else begin
                next_out_sh = {out_sh[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state    <= ST_IDLE;
            busy     <= BUSY_NONE;
            cs_q     <= 1'b1;
            sclk_q   <= 1'b0;
            cmd      <= 8'h00;
            sh       <= 8'h00;
            bcnt     <= 4'h0;
            abyte    <= 2'h0;
            addr     <= 24'h000000;
            ptr      <= 8'h00;
            out_sh   <= 8'h00;
            busy_cnt <= 16'h0000;
            page     <= 16'h0000;
        end else begin
            state    <= next_state;
            busy     <= next_busy;
            cs_q     <= next_cs_q;
            sclk_q   <= next_sclk_q;
            cmd      <= next_cmd;
            sh       <= next_sh;
            bcnt     <= next_bcnt;
            abyte    <= next_abyte;
            addr     <= next_addr;
            ptr      <= next_ptr;
            out_sh   <= next_out_sh;
            busy_cnt <= next_busy_cnt;
            page     <= next_page;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_write_in_progress_flag = (busy != BUSY_NONE);
    assign o_mem_rd   = (busy == BUSY_LOAD) && fill_on;
    assign o_mem_addr = {page, busy_cnt[7:0]};
    assign o_io       = i_quad_command_mode ? out_sh[7:4] : {2'b00, out_sh[7], 1'b0};
    // Drive only in the data phase; select high drops it at once
    assign o_io_oe    = (state != ST_RDATA || i_cs_n) ? 4'h0 :
                        (i_quad_command_mode ? 4'hF : 4'h2);

endmodule : sfpb_core

/* File: core/sfpb_pkg.sv */
// Purpose: Shared constants and types for the serial flash page buffer commands.
// Assumes: 25 MHz system clock; serial pins already synchronous to it.
// Notes:   Operation summary below; sfpb_core carries the logic.
//
// Operation
// - Buffer clear writes FF into all 256 buffer bytes.
// - Clear starts on chip select rise; host waits clear latency before next command.
// - Buffer load takes 3 address bytes; bits 23..8 pick the copied page.
// - Load starts on select rise; busy flag shows it until transfer time ends.
// - Buffer read: opcode, three address bytes, one dummy byte, then data out.
// - Read starts anywhere, address increments per byte and wraps to zero.
// - Raising select ends a read at any point; output drive stops.
// - Buffer read rejected while program, erase or status write runs.
// - Write stores each byte, increments, wraps at 256, until select rises.
// - Busy flag is one during self-timed cycles, zero once complete.
package sfpb_pkg;

    // ------------------------------------------------------------------
    // Opcodes and buffer shape
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_BUF_CLEAR = 8'h9E;
    localparam logic [7:0]  OP_BUF_LOAD  = 8'h9B;
    localparam logic [7:0]  OP_BUF_READ  = 8'h9D;
    localparam logic [7:0]  OP_BUF_WRITE = 8'h9C;
    localparam logic [7:0]  FILL_BYTE    = 8'hFF;
    localparam logic [8:0]  BUF_DEPTH    = 9'h100;
    localparam logic [1:0]  ADDR_LAST    = 2'h2;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam logic [3:0]  STEP_SINGLE  = 4'h1;
    localparam logic [3:0]  STEP_QUAD    = 4'h4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          SYS_CLK_MHZ           = 25;
    localparam int          CLEAR_LATENCY_TIME_NS = 20000;
    localparam int          PAGE_TRANSFER_TIME_NS = 40000;
    localparam logic [15:0] CLEAR_CYCLES =
        16'((CLEAR_LATENCY_TIME_NS * SYS_CLK_MHZ + 999) / 1000);
    localparam logic [15:0] XFER_CYCLES  =
        16'((PAGE_TRANSFER_TIME_NS * SYS_CLK_MHZ + 999) / 1000);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_OP, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_ARMED, ST_IGNORE
    } sfpb_state_e;

    typedef enum logic [1:0] {
        BUSY_NONE, BUSY_CLEAR, BUSY_LOAD
    } sfpb_busy_e;

endpackage : sfpb_pkg

/* File: core/sfpb_buf_ram.sv */
// Purpose: 256 x 8 page buffer storage, one write and one read port.
// Assumes: Single clock; read data registered.
// Notes:   Contents are not reset, as in the real array.
`timescale 1ns/1ps
module sfpb_buf_ram
    import sfpb_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // Write port
    input  wire logic       i_we,
    input  wire logic [7:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    // Read port
    input  wire logic [7:0] i_raddr,
    output logic      [7:0] o_rdata
);

    logic [7:0] mem [0:255];

    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule : sfpb_buf_ram

/* File: verification/sfpb_core_sva.sv */
// Purpose: Port checks for sfpb_core.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every sfpb_core instance.
`timescale 1ns/1ps
module sfpb_core_sva
    import sfpb_pkg::*;
(
    // Clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    // Serial pins
    input wire logic        i_cs_n,
    input wire logic        i_sclk,
    input wire logic [3:0]  i_io,
    input wire logic [3:0]  o_io,
    input wire logic [3:0]  o_io_oe,
    // Mode, status and memory
    input wire logic        i_quad_command_mode,
    input wire logic        i_ext_busy,
    input wire logic        o_write_in_progress_flag,
    input wire logic        o_mem_rd,
    input wire logic [23:0] o_mem_addr,
    input wire logic [7:0]  i_mem_rdata
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ----------------------------------------
    // Busy length counter
    // ----------------------------------------
    logic [10:0] hi_cnt;
    logic [10:0] next_hi_cnt;
    always_comb begin
        next_hi_cnt = o_write_in_progress_flag ? hi_cnt + 11'h001 : 11'h000;
    end
    always_ff @(posedge i_sys_clk) begin
        hi_cnt <= i_rst ? 11'h000 : next_hi_cnt;
    end
    sequence s_fetch_run; o_mem_rd [*8]; endsequence
    property p_oe_off; i_cs_n |-> o_io_oe == 4'h0; endproperty
    property p_oe_lanes; |o_io_oe |-> o_io_oe == (i_quad_command_mode ? 4'hF : 4'h2); endproperty
    property p_idle_lanes; (|o_io_oe && !i_quad_command_mode) |-> (o_io & 4'hD) == 4'h0; endproperty
    property p_fetch_busy; o_mem_rd |-> o_write_in_progress_flag; endproperty
    property p_fetch_start; $rose(o_mem_rd) |-> o_mem_addr[7:0] == 8'h00 ##1 s_fetch_run; endproperty
    property p_fetch_step; o_mem_rd && $past(o_mem_rd) |-> o_mem_addr == $past(o_mem_addr) + 24'h1;
    endproperty
    property p_flag_cause; $rose(o_write_in_progress_flag) |-> $past(i_cs_n); endproperty
    property p_flag_len; $fell(o_write_in_progress_flag) |->
        16'($past(hi_cnt)) >= CLEAR_CYCLES - 16'h2 && 16'($past(hi_cnt)) <= XFER_CYCLES; endproperty
    property p_flag_bound; 16'(hi_cnt) <= XFER_CYCLES + 16'h1; endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive while deselected");
    a_oe_lanes: assert property (p_oe_lanes) else $error("wrong lanes driven");
    a_idle_lanes: assert property (p_idle_lanes) else $error("unused lane not low");
    a_fetch_busy: assert property (p_fetch_busy) else $error("fetch while idle");
    a_fetch_start: assert property (p_fetch_start) else $error("fetch start wrong");
    a_fetch_step: assert property (p_fetch_step) else $error("fetch address step");
    a_flag_cause: assert property (p_flag_cause) else $error("busy without select rise");
    a_flag_len: assert property (p_flag_len) else $error("busy length wrong");
    a_flag_bound: assert property (p_flag_bound) else $error("busy too long");
endmodule : sfpb_core_sva
bind sfpb_core sfpb_core_sva sfpb_core_sva_i (.i_sys_clk, .i_rst, .i_cs_n, .i_sclk, .i_io, .o_io,
    .o_io_oe, .i_quad_command_mode, .i_ext_busy, .o_write_in_progress_flag, .o_mem_rd,
    .o_mem_addr, .i_mem_rdata);

/* File: verification/sfpb_mem_model.sv */
// Purpose: Main memory behind the buffer load port.
// Assumes: Combinational read, as the core expects.
// Notes:   Pattern mixes page and index so a wrong page shows.
`timescale 1ns/1ps
module sfpb_mem_model (
    // Read port
    input  wire logic        i_mem_rd,
    input  wire logic [23:0] i_mem_addr,
    output logic      [7:0]  o_mem_rdata
);
    // Inverted outside fetch so stale data never looks right
    assign o_mem_rdata = (i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ i_mem_addr[23:16])
        ^ (i_mem_rd ? 8'h00 : 8'hFF);
endmodule : sfpb_mem_model

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for sfpb_core.
// Assumes: Serial clock low for four system cycles, high for three.
// Notes:   Order: clear, write, load, busy read, abort, quad, refused frames.
`timescale 1ns/1ps
module tb_top
    import sfpb_pkg::*;
;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, cs_n = 1'b1, sclk = 1'b0, quad = 1'b0, ebusy = 1'b0;
    logic [3:0] io = 4'h0, o_io, o_io_oe;
    logic flag, mem_rd;
    logic [23:0] mem_addr;
    logic [7:0] mem_rdata;
    int miscompares = 0, cmp_count = 0;
    always #20 i_sys_clk = ~i_sys_clk;
    sfpb_mem_model sfpb_mem_model_i (.i_mem_rd(mem_rd), .i_mem_addr(mem_addr),
        .o_mem_rdata(mem_rdata));
    sfpb_core sfpb_core_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_io(io), .o_io(o_io), .o_io_oe(o_io_oe), .i_quad_command_mode(quad),
        .i_ext_busy(ebusy), .o_write_in_progress_flag(flag), .o_mem_rd(mem_rd),
        .o_mem_addr(mem_addr), .i_mem_rdata(mem_rdata));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run();
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic edge_wait(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : edge_wait
    task automatic sel(input logic v);
        @(posedge i_sys_clk);
        cs_n <= v;
        edge_wait(2);
    endtask : sel
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int k = 0; k < (quad ? 2 : 8); k++) begin
            @(posedge i_sys_clk);
            sclk <= 1'b0;
            io <= quad ? tx[7:4] : {3'h0, tx[7]};
            tx = quad ? (tx << 4) : (tx << 1);
            edge_wait(3);
            @(negedge i_sys_clk);
            rx = quad ? {rx[3:0], o_io} : {rx[6:0], o_io[1]};
            @(posedge i_sys_clk);
            sclk <= 1'b1;
            edge_wait(2);
        end
    endtask : xfer
    task automatic head(input logic [7:0] op, input logic [23:0] a, input logic dummy);
        logic [7:0] d;
        sel(1'b0);
        xfer(op, d);
        for (int k = 2; k >= 0; k--) xfer(a[8*k+:8], d);
        if (dummy) xfer(8'h00, d);
    endtask : head
    task automatic busy_time(input logic [15:0] cyc);
        int n;
        n = 0;
        @(negedge i_sys_clk);
        check("busy start", {7'h00, flag}, 8'h01);
        while (flag !== 1'b0) begin
            @(negedge i_sys_clk);
            n++;
            if (n > 1200) begin
                miscompares++;
                complete_run();
            end
        end
        check("busy time", 8'(n >= int'(cyc) - 4 && n <= int'(cyc)), 8'h01);
    endtask : busy_time
    task automatic read_check(input logic [23:0] a, input logic [7:0] exp [4]);
        logic [7:0] d;
        head(OP_BUF_READ, a, 1'b1);
        for (int k = 0; k < 4; k++) begin
            xfer(8'h00, d);
            check("read byte", d, exp[k]);
        end
        sel(1'b1);
    endtask : read_check
    task automatic write_buf(input logic [23:0] a, input logic [7:0] b0, input logic [7:0] b1);
        logic [7:0] d;
        head(OP_BUF_WRITE, a, 1'b0);
        xfer(b0, d);
        xfer(b1, d);
        sel(1'b1);
    endtask : write_buf
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_clear();
        logic [7:0] d;
        sel(1'b0);
        xfer(OP_BUF_CLEAR, d);
        sel(1'b1);
        busy_time(CLEAR_CYCLES);
        read_check(24'h0000FE, '{8'hFF, 8'hFF, 8'hFF, 8'hFF});
    endtask : t_clear
    task automatic t_write_wrap();
        write_buf(24'h0000FF, 8'h11, 8'h22);
        read_check(24'hC3A5FE, '{8'hFF, 8'h11, 8'h22, 8'hFF});
    endtask : t_write_wrap
    task automatic t_load();
        head(OP_BUF_LOAD, 24'h1234AB, 1'b0);
        sel(1'b1);
        busy_time(XFER_CYCLES);
        read_check(24'h0000FF, '{8'hD9, 8'h26, 8'h27, 8'h24});
    endtask : t_load
    task automatic t_busy_abort();
        logic [7:0] d;
        @(posedge i_sys_clk);
        ebusy <= 1'b1;
        head(OP_BUF_READ, 24'h000000, 1'b1);
        xfer(8'h00, d);
        @(negedge i_sys_clk);
        check("oe while busy", {4'h0, o_io_oe}, 8'h00);
        sel(1'b1);
        ebusy <= 1'b0;
        head(OP_BUF_READ, 24'h000000, 1'b1);
        xfer(8'h00, d);
        @(negedge i_sys_clk);
        check("oe in read", {4'h0, o_io_oe}, 8'h02);
        @(posedge i_sys_clk);
        cs_n <= 1'b1;
        edge_wait(1);
        @(negedge i_sys_clk);
        check("oe after abort", {4'h0, o_io_oe}, 8'h00);
        edge_wait(2);
    endtask : t_busy_abort
    task automatic t_quad();
        @(posedge i_sys_clk);
        quad <= 1'b1;
        write_buf(24'h000010, 8'hA5, 8'h5A);
        read_check(24'h000010, '{8'hA5, 8'h5A, 8'h34, 8'h35});
    endtask : t_quad
    task automatic t_refuse();
        logic [7:0] d;
        int n;
        n = 0;
        // Clear with a trailing byte must not start
        sel(1'b0);
        xfer(OP_BUF_CLEAR, d);
        xfer(8'h00, d);
        sel(1'b1);
        @(negedge i_sys_clk);
        check("busy after long clear", {7'h00, flag}, 8'h00);
        // Write frame inside the clear latency must be dropped
        sel(1'b0);
        xfer(OP_BUF_CLEAR, d);
        sel(1'b1);
        write_buf(24'h000010, 8'h77, 8'h88);
        while (flag !== 1'b0) begin
            @(negedge i_sys_clk);
            n++;
            if (n > 1200) begin
                miscompares++;
                complete_run();
            end
        end
        read_check(24'h000010, '{8'hFF, 8'hFF, 8'hFF, 8'hFF});
    endtask : t_refuse
    initial begin
        edge_wait(8);
        i_rst <= 1'b0;
        t_clear();
        t_write_wrap();
        t_load();
        t_busy_abort();
        t_quad();
        t_refuse();
        complete_run();
    end
endmodule : tb_top
